// ===== src/fault_and_status_registers.sv
// fault and status register bank behind a two-wire serial peripheral
// assumes open-drain SDA resolved outside, pins asynchronous, busy_in local
// How it works
// - any data access at the wipe address clears all latched fault flags except those whose event is present in the wipe cycle
// - fault flags stay set until wiped through the wipe address
// - flag bit 7 shows peak limit pin left open
// - flag bit 6 shows reference shorted to bias supply
// - flag bits 5 and 4 show bootstrap undervoltage, channel 1 and 2
// - flag bits 3 and 2 show current cap hit, channel 1 and 2
// - flag bit 1 shows an overvoltage fault
// - flag bit 0 shows an overtemperature shutdown
// - first status bits 7 and 6 show channel 1 and 2 enabled
// - first status bits 5 and 4 show diode emulation, else forced switching
// - first status bits 3 and 2 show the flow direction pin levels
// - first status bits 1 and 0 flag a bad direction command
// - second status bit 7 shows oscillator pin short
// - second status bit 6 shows input lockout active
// - second status bit 5 shows the select pin level
// - second status bits 4 and 3 show soft-start complete per channel
// - second status bit 2 shows shutdown held by its pin
// - second status bit 1 shows adaptive deadtime selected
// - second status bit 0 shows bias supply undervoltage
// - address with write bit, register byte, then repeated start reads a byte
// - an acknowledged read byte advances the pointer and sends the next register
// - no clock stretching; a busy device leaves its address unacknowledged
`default_nettype none
module fault_and_status_registers
  import pwr_regs_pkg::*;
#(
  parameter logic [6:0] PERIPH_ADDR = 7'h40
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_data_out,
  output logic sda_oe_n_out,
  input wire logic busy_in,
  input wire logic peak_limit_pin_open_in,
  input wire logic ref_short_in,
  input wire logic ch1_bootstrap_low_in,
  input wire logic ch2_bootstrap_low_in,
  input wire logic ch1_current_cap_hit_in,
  input wire logic ch2_current_cap_hit_in,
  input wire logic overvoltage_fault_in,
  input wire logic overtemp_fault_in,
  input wire logic ch1_active_in,
  input wire logic ch2_active_in,
  input wire logic ch1_diode_emulation_in,
  input wire logic ch2_diode_emulation_in,
  input wire logic ch1_flow_sense_in,
  input wire logic ch2_flow_sense_in,
  input wire logic ch1_flow_cmd_bad_in,
  input wire logic ch2_flow_cmd_bad_in,
  input wire logic oscillator_pin_short_in,
  input wire logic input_lockout_in,
  input wire logic select_pin_level_in,
  input wire logic ch1_softstart_complete_in,
  input wire logic ch2_softstart_complete_in,
  input wire logic shutdown_state_in,
  input wire logic auto_deadtime_active_in,
  input wire logic bias_supply_low_in
);
  localparam int SYNC_W = 26;
  typedef struct packed {
    link_state_t st;
    logic [7:0] shreg;
    logic [2:0] bitn;
    logic byte_done;
    logic rw;
    logic [7:0] ptr;
    logic sda_rel;
    logic sda_lvl;
    logic wipe;
    logic scl_q;
    logic sda_q;
  } ctl_t;
  ctl_t c;
  ctl_t next_c;
  logic [7:0] raw_flt, raw_a, raw_b;
  logic [SYNC_W-1:0] filt;
  logic [7:0] flt_ev, state_a, state_b, fault_flags;
  logic scl_f, sda_f, scl_rise, scl_fall;
  logic start_seen, stop_seen;
  logic [7:0] rd_cur, rd_nxt, ptr_inc;
  // ****************************************
  // register read mux
  // ****************************************
  // reserved addresses read zero and have no side effect
  function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [7:0] f,
                                         input logic [7:0] sa, input logic [7:0] sb);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      WIPE_ADDR: r = WIPE_RST;
      FLAGS_ADDR: r = f;
      STATE_A_ADDR: r = sa;
      STATE_B_ADDR: r = sb;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : rd_byte

  // ****************************************
  // pin gathering
  // ****************************************
  // fault events in flag order
  always_comb begin
    raw_flt = 8'h00;
    raw_flt[PEAK_OPEN_BIT] = peak_limit_pin_open_in;
    raw_flt[REF_SHORT_BIT] = ref_short_in;
    raw_flt[CH1_BOOT_BIT] = ch1_bootstrap_low_in;
    raw_flt[CH2_BOOT_BIT] = ch2_bootstrap_low_in;
    raw_flt[CH1_CAP_BIT] = ch1_current_cap_hit_in;
    raw_flt[CH2_CAP_BIT] = ch2_current_cap_hit_in;
    raw_flt[OVERVOLT_BIT] = overvoltage_fault_in;
    raw_flt[OVERTEMP_BIT] = overtemp_fault_in;
  end

  // live channel state, first status register
  always_comb begin
    raw_a = STATE_A_RST;
    raw_a[CH1_ACT_BIT] = ch1_active_in;
    raw_a[CH2_ACT_BIT] = ch2_active_in;
    raw_a[CH1_DIODE_BIT] = ch1_diode_emulation_in;
    raw_a[CH2_DIODE_BIT] = ch2_diode_emulation_in;
    raw_a[CH1_FLOW_BIT] = ch1_flow_sense_in;
    raw_a[CH2_FLOW_BIT] = ch2_flow_sense_in;
    raw_a[CH1_BAD_BIT] = ch1_flow_cmd_bad_in;
    raw_a[CH2_BAD_BIT] = ch2_flow_cmd_bad_in;
  end

  // live part state, second status register
  always_comb begin
    raw_b = STATE_B_RST;
    raw_b[OSC_SHORT_BIT] = oscillator_pin_short_in;
    raw_b[LOCKOUT_BIT] = input_lockout_in;
    raw_b[SELECT_BIT] = select_pin_level_in;
    raw_b[CH1_SOFT_BIT] = ch1_softstart_complete_in;
    raw_b[CH2_SOFT_BIT] = ch2_softstart_complete_in;
    raw_b[SHUTDOWN_BIT] = shutdown_state_in;
    raw_b[AUTO_DT_BIT] = auto_deadtime_active_in;
    raw_b[BIAS_LOW_BIT] = bias_supply_low_in;
  end

  // ****************************************
  // synchronisers and fault latch
  // ****************************************
  pin_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .raw_in({raw_b, raw_a, raw_flt, scl_in, sda_in}),
    .filt_out(filt)
  );

  // split the filtered lanes back out
  assign sda_f = filt[0];
  assign scl_f = filt[1];
  assign flt_ev = filt[9:2];
  assign state_a = filt[17:10];
  assign state_b = filt[25:18];

  fault_latch #(
    .WIDTH(8)
  ) u_latch (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .event_in(flt_ev),
    .wipe_in(c.wipe),
    .flags_out(fault_flags)
  );

  // ****************************************
  // line events and read data
  // ****************************************
  // start and stop are SDA edges while SCL stays high
  assign scl_rise = scl_f & ~c.scl_q;
  assign scl_fall = ~scl_f & c.scl_q;
  assign start_seen = scl_f & c.scl_q & c.sda_q & ~sda_f;
  assign stop_seen = scl_f & c.scl_q & ~c.sda_q & sda_f;
  assign ptr_inc = c.ptr + 8'h01;
  assign rd_cur = rd_byte(c.ptr, fault_flags, state_a, state_b);
  assign rd_nxt = rd_byte(ptr_inc, fault_flags, state_a, state_b);

  // ****************************************
  // serial sequencer
  // ****************************************
  // SDA is only changed after SCL falls, never held to stretch SCL
  always_comb begin
    next_c = c;
    next_c.wipe = 1'b0;
    next_c.scl_q = scl_f;
    next_c.sda_q = sda_f;
    if (stop_seen) begin
      next_c.st = LS_IDLE;
      next_c.sda_rel = 1'b1;
    end else if (start_seen) begin
      next_c.st = LS_ADDR;
      next_c.bitn = 3'd0;
      next_c.byte_done = 1'b0;
      next_c.sda_rel = 1'b1;
    end else begin
      unique case (c.st)
        LS_IDLE, LS_IGNORE: begin
          next_c.sda_rel = 1'b1;
        end
        LS_ADDR, LS_REG, LS_WDATA: begin
          if (scl_rise) begin
            next_c.shreg = {c.shreg[6:0], sda_f};
            next_c.bitn = c.bitn + 3'd1;
            next_c.byte_done = (c.bitn == 3'd7);
          end else if (scl_fall && c.byte_done) begin
            next_c.byte_done = 1'b0;
            next_c.sda_rel = 1'b0;
            if (c.st == LS_ADDR) begin
              if (c.shreg[7:1] == PERIPH_ADDR && !busy_in) begin
                next_c.rw = c.shreg[0];
                next_c.st = LS_ADDR_ACK;
              end else begin
                next_c.sda_rel = 1'b1;
                next_c.st = LS_IGNORE;
              end
            end else if (c.st == LS_REG) begin
              next_c.ptr = c.shreg;
              next_c.st = LS_REG_ACK;
            end else begin
              next_c.wipe = (c.ptr == WIPE_ADDR);
              next_c.st = LS_WDATA_ACK;
            end
          end
        end
        LS_ADDR_ACK: begin
          if (scl_fall) begin
            next_c.bitn = 3'd0;
            if (c.rw) begin
              next_c.shreg = rd_cur;
              next_c.sda_rel = rd_cur[7];
              next_c.wipe = (c.ptr == WIPE_ADDR);
              next_c.st = LS_RDATA;
            end else begin
              next_c.sda_rel = 1'b1;
              next_c.st = LS_REG;
            end
          end
        end
        LS_REG_ACK: begin
          if (scl_fall) begin
            next_c.sda_rel = 1'b1;
            next_c.bitn = 3'd0;
            next_c.st = LS_WDATA;
          end
        end
        LS_WDATA_ACK: begin
          if (scl_fall) begin
            next_c.sda_rel = 1'b1;
            next_c.bitn = 3'd0;
            next_c.ptr = ptr_inc;
            next_c.st = LS_WDATA;
          end
        end
        LS_RDATA: begin
          if (scl_fall) begin
            if (c.bitn == 3'd7) begin
              next_c.sda_rel = 1'b1;
              next_c.st = LS_RDATA_ACK;
            end else begin
              next_c.shreg = {c.shreg[6:0], 1'b0};
              next_c.sda_rel = c.shreg[6];
              next_c.bitn = c.bitn + 3'd1;
            end
          end
        end
        LS_RDATA_ACK: begin
          if (scl_rise) begin
            next_c.byte_done = ~sda_f;
          end else if (scl_fall) begin
            next_c.byte_done = 1'b0;
            next_c.bitn = 3'd0;
            if (c.byte_done) begin
              next_c.ptr = ptr_inc;
              next_c.shreg = rd_nxt;
              next_c.sda_rel = rd_nxt[7];
              next_c.wipe = (ptr_inc == WIPE_ADDR);
              next_c.st = LS_RDATA;
            end else begin
              next_c.st = LS_IGNORE;
            end
          end
        end
      endcase
    end
  end

  // registered state, released SDA after reset
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      c <= '0;
      c.sda_rel <= 1'b1;
    end else begin
      c <= next_c;
    end
  end

  assign sda_data_out = c.sda_lvl;
  assign sda_oe_n_out = c.sda_rel;
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);
  sequence s_enter_read;
    (c.st != LS_RDATA) ##1 (c.st == LS_RDATA);
  endsequence
  sequence s_write_done;
    (c.st == LS_WDATA) && scl_fall && c.byte_done;
  endsequence
  property p_wipe_write;
    s_write_done ##0 (c.ptr == WIPE_ADDR) |=> c.wipe ##1 (fault_flags == $past(flt_ev));
  endproperty
  a_wipe_write: assert property (p_wipe_write) else $error("wipe write missed");
  property p_ro_ignored;
    s_write_done ##0 (c.ptr != WIPE_ADDR) |=> !c.wipe;
  endproperty
  a_ro_ignored: assert property (p_ro_ignored) else $error("read-only write acted");
  property p_flags_held;
    !c.wipe |=> ((fault_flags & $past(fault_flags)) == $past(fault_flags));
  endproperty
  a_flags_held: assert property (p_flags_held) else $error("flag lost");
  property p_peak_open;
    flt_ev[PEAK_OPEN_BIT] |=> fault_flags[PEAK_OPEN_BIT];
  endproperty
  a_peak_open: assert property (p_peak_open) else $error("open pin not latched");
  property p_read_flags;
    s_enter_read ##0 (c.ptr == FLAGS_ADDR) |-> c.shreg == $past(fault_flags);
  endproperty
  a_read_flags: assert property (p_read_flags) else $error("bad flag read");
  property p_read_a;
    s_enter_read ##0 (c.ptr == STATE_A_ADDR) |-> c.shreg == $past(state_a);
  endproperty
  a_read_a: assert property (p_read_a) else $error("bad status a read");
  property p_read_b;
    s_enter_read ##0 (c.ptr == STATE_B_ADDR) |-> c.shreg == $past(state_b);
  endproperty
  a_read_b: assert property (p_read_b) else $error("bad status b read");
  property p_ack_low;
    (c.st inside {LS_ADDR_ACK, LS_REG_ACK, LS_WDATA_ACK}) |-> !c.sda_rel;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack not driven");
  property p_shift_out;
    (c.st == LS_RDATA) && scl_fall && (c.bitn != 3'd7) |=> c.sda_rel == $past(c.shreg[6]);
  endproperty
  a_shift_out: assert property (p_shift_out) else $error("read bit wrong");
  property p_next_reg;
    (c.st == LS_RDATA_ACK) && scl_fall && c.byte_done |=> c.ptr == $past(ptr_inc);
  endproperty
  a_next_reg: assert property (p_next_reg) else $error("pointer not advanced");
  property p_busy_nack;
    $rose(c.st == LS_ADDR_ACK) |-> !$past(busy_in);
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("acked while busy");
endmodule : fault_and_status_registers
`default_nettype wire

// ===== common/pwr_regs_pkg.sv
// shared constants of the fault and status register bank
// assumes one 100 MHz clock and a two-wire serial peripheral port
`default_nettype none
package pwr_regs_pkg;
  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [7:0] WIPE_ADDR = 8'h03;
  localparam logic [7:0] FLAGS_ADDR = 8'h78;
  localparam logic [7:0] STATE_A_ADDR = 8'hd0;
  localparam logic [7:0] STATE_B_ADDR = 8'hd1;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] WIPE_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] STATE_A_RST = 8'h00;
  localparam logic [7:0] STATE_B_RST = 8'h00;
  // ****************************************
  // fault flag positions
  // ****************************************
  localparam int PEAK_OPEN_BIT = 7;
  localparam int REF_SHORT_BIT = 6;
  localparam int CH1_BOOT_BIT = 5;
  localparam int CH2_BOOT_BIT = 4;
  localparam int CH1_CAP_BIT = 3;
  localparam int CH2_CAP_BIT = 2;
  localparam int OVERVOLT_BIT = 1;
  localparam int OVERTEMP_BIT = 0;
  // ****************************************
  // first status register positions
  // ****************************************
  localparam int CH1_ACT_BIT = 7;
  localparam int CH2_ACT_BIT = 6;
  localparam int CH1_DIODE_BIT = 5;
  localparam int CH2_DIODE_BIT = 4;
  localparam int CH1_FLOW_BIT = 3;
  localparam int CH2_FLOW_BIT = 2;
  localparam int CH1_BAD_BIT = 1;
  localparam int CH2_BAD_BIT = 0;
  // ****************************************
  // second status register positions
  // ****************************************
  localparam int OSC_SHORT_BIT = 7;
  localparam int LOCKOUT_BIT = 6;
  localparam int SELECT_BIT = 5;
  localparam int CH1_SOFT_BIT = 4;
  localparam int CH2_SOFT_BIT = 3;
  localparam int SHUTDOWN_BIT = 2;
  localparam int AUTO_DT_BIT = 1;
  localparam int BIAS_LOW_BIT = 0;
  // serial link sequencer states
  typedef enum {
    LS_IDLE, LS_ADDR, LS_ADDR_ACK, LS_REG, LS_REG_ACK,
    LS_WDATA, LS_WDATA_ACK, LS_RDATA, LS_RDATA_ACK, LS_IGNORE
  } link_state_t;
endpackage : pwr_regs_pkg
`default_nettype wire

// ===== src/pin_sync.sv
// three-stage synchroniser with agreement filter, one lane per bit
// assumes asynchronous pins and one clock
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] raw_in,
  output logic [WIDTH-1:0] filt_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] filt;
  } sync_t;
  sync_t c;
  sync_t next_c;
  if (WIDTH < 1) begin : g_chk
    $error("pin_sync width must be at least one");
  end
  // ****************************************
  // shift and filter
  // ****************************************
  // a lane moves only once the second and third stages agree
  always_comb begin
    next_c = c;
    next_c.s1 = raw_in;
    next_c.s2 = c.s1;
    next_c.s3 = c.s2;
    next_c.filt = (c.s3 & ~(c.s2 ^ c.s3)) | (c.filt & (c.s2 ^ c.s3));
  end
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end
  assign filt_out = c.filt;
  // filter never moves to a value the last two stages disagree on
  property p_agree;
    @(posedge mclk_in) disable iff (!nrst_in)
      (c.filt != $past(c.filt)) |-> ((c.filt ^ $past(c.filt)) & $past(c.s2 ^ c.s3)) == '0;
  endproperty
  a_agree: assert property (p_agree) else $error("filter moved on disagreement");
endmodule : pin_sync
`default_nettype wire

// ===== src/fault_latch.sv
// sticky fault flags, set by events and wiped by one pulse
// assumes events already on the local clock
`default_nettype none
module fault_latch
  import pwr_regs_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] event_in,
  input wire logic wipe_in,
  output logic [WIDTH-1:0] flags_out
);
  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } latch_t;
  latch_t c;
  latch_t next_c;
  if (WIDTH < 1 || WIDTH > 8) begin : g_chk
    $error("fault_latch width must be 1 to 8");
  end
  // ****************************************
  // latch and wipe
  // ****************************************
  // an event in the wipe cycle survives the wipe
  always_comb begin
    next_c = c;
    next_c.flags = (c.flags & ~{WIDTH{wipe_in}}) | event_in;
  end
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      c.flags <= FLAGS_RST[WIDTH-1:0];
    end else begin
      c <= next_c;
    end
  end
  assign flags_out = c.flags;
  property p_set_wins;
    @(posedge mclk_in) disable iff (!nrst_in)
      (wipe_in && event_in != '0) |=> ((flags_out & $past(event_in)) == $past(event_in));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to wipe");
  property p_hold;
    @(posedge mclk_in) disable iff (!nrst_in)
      !wipe_in |=> ((flags_out & $past(flags_out)) == $past(flags_out));
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without wipe");
endmodule : fault_latch
`default_nettype wire

// ===== test/i2c_ctrl_model.sv
// two-wire bus controller model: start, stop and one byte transfer
// assumes the bench resolves the pulled-up data wire into sda_in
`default_nettype none
module i2c_ctrl_model (
  input wire logic mclk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 8; // clocks per scl phase
  // ************
  // bus primitives
  // ************
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : tick
  // start or repeated start: data falls while clock high
  task automatic start();
    tick(2);
    sda_out <= 1'b1;
    tick(HALF);
    scl_out <= 1'b1;
    tick(HALF);
    sda_out <= 1'b0;
    tick(HALF);
    scl_out <= 1'b0;
  endtask : start
  // stop: data rises while clock high
  task automatic stop();
    tick(2);
    sda_out <= 1'b0;
    tick(HALF);
    scl_out <= 1'b1;
    tick(HALF);
    sda_out <= 1'b1;
    tick(HALF);
  endtask : stop
  // data set while clock low, wire sampled at end of high
  task automatic bit_xfer(input logic b, output logic r);
    tick(2);
    sda_out <= b;
    tick(HALF);
    scl_out <= 1'b1;
    tick(HALF);
    r = sda_in;
    scl_out <= 1'b0;
  endtask : bit_xfer
  // msb first, then the ninth bit; a released bit reads the device
  task automatic byte_xfer(input logic [7:0] d, input logic ack_in,
                           output logic [7:0] r, output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r[i]);
    end
    bit_xfer(ack_in, ack_out);
  endtask : byte_xfer
endmodule : i2c_ctrl_model
`default_nettype wire

// ===== test/tb.sv
// self-checking bench of the fault and status register bank
// assumes the controller model i2c_ctrl_model and the register package
`default_nettype none
module tb
  import pwr_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] DEV = 7'h40; // peripheral address
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic busy = 1'b0;
  logic [7:0] ev = 8'h00;
  logic [7:0] sa = 8'h00;
  logic [7:0] sb = 8'h00;
  int num_errors = 0;
  int cmp_count = 0;
  wire scl;
  wire sda_m;
  wire sda_data;
  wire sda_oe_n;
  // pulled-up wire, low when either side pulls
  wire sda = sda_m & (sda_oe_n | sda_data);
  fault_and_status_registers #(.PERIPH_ADDR(DEV)) fault_and_status_registers_i (
    .mclk_in(mclk), .nrst_in(nrst), .scl_in(scl), .sda_in(sda), .sda_data_out(sda_data),
    .sda_oe_n_out(sda_oe_n), .busy_in(busy),
    .peak_limit_pin_open_in(ev[7]), .ref_short_in(ev[6]), .ch1_bootstrap_low_in(ev[5]),
    .ch2_bootstrap_low_in(ev[4]), .ch1_current_cap_hit_in(ev[3]),
    .ch2_current_cap_hit_in(ev[2]), .overvoltage_fault_in(ev[1]), .overtemp_fault_in(ev[0]),
    .ch1_active_in(sa[7]), .ch2_active_in(sa[6]), .ch1_diode_emulation_in(sa[5]),
    .ch2_diode_emulation_in(sa[4]), .ch1_flow_sense_in(sa[3]), .ch2_flow_sense_in(sa[2]),
    .ch1_flow_cmd_bad_in(sa[1]), .ch2_flow_cmd_bad_in(sa[0]),
    .oscillator_pin_short_in(sb[7]), .input_lockout_in(sb[6]), .select_pin_level_in(sb[5]),
    .ch1_softstart_complete_in(sb[4]), .ch2_softstart_complete_in(sb[3]),
    .shutdown_state_in(sb[2]), .auto_deadtime_active_in(sb[1]), .bias_supply_low_in(sb[0])
  );
  i2c_ctrl_model i2c_ctrl_model_i (.mclk_in(mclk), .sda_in(sda), .scl_out(scl),
    .sda_out(sda_m));
  // ************
  // helpers
  // ************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
  endtask : settle
  // address for writing and name a register; nak gathers refusals
  task automatic point(input logic [7:0] a, output logic nak);
    logic [7:0] r;
    logic k0;
    logic k1;
    i2c_ctrl_model_i.start();
    i2c_ctrl_model_i.byte_xfer({DEV, 1'b0}, 1'b1, r, k0);
    i2c_ctrl_model_i.byte_xfer(a, 1'b1, r, k1);
    nak = k0 | k1;
  endtask : point
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic k0;
    logic k1;
    point(a, k0);
    i2c_ctrl_model_i.byte_xfer(d, 1'b1, r, k1);
    i2c_ctrl_model_i.stop();
    check({7'h00, k0 | k1}, 8'h00);
  endtask : reg_wr
  // one byte, or two with the first acknowledged
  task automatic reg_rd(input logic [7:0] a, input logic two, output logic [7:0] d0,
                        output logic [7:0] d1);
    logic k0;
    logic k1;
    logic kx;
    point(a, k0);
    i2c_ctrl_model_i.start();
    i2c_ctrl_model_i.byte_xfer({DEV, 1'b1}, 1'b1, d1, k1);
    i2c_ctrl_model_i.byte_xfer(8'hff, !two, d0, kx);
    d1 = 8'h00;
    if (two) i2c_ctrl_model_i.byte_xfer(8'hff, 1'b1, d1, kx);
    i2c_ctrl_model_i.stop();
    check({7'h00, k0 | k1}, 8'h00);
  endtask : reg_rd
  // ************
  // scenarios
  // ************
  task automatic t_reset();
    logic [7:0] d0;
    logic [7:0] d1;
    settle(20);
    check({7'h00, sda_oe_n}, 8'h01);
    check({7'h00, sda_data}, 8'h00);
    nrst <= 1'b1;
    settle(4);
    reg_rd(FLAGS_ADDR, 1'b0, d0, d1);
    check(d0, FLAGS_RST);
    reg_rd(STATE_A_ADDR, 1'b1, d0, d1);
    check(d0, STATE_A_RST);
    check(d1, STATE_B_RST);
  endtask : t_reset
  // each event sets its own flag, kept after the event ends; a write to the wipe place wipes
  task automatic t_flags();
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] exp;
    exp = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      ev <= 8'h01 << i;
      settle(6);
      ev <= 8'h00;
      exp[i] = 1'b1;
      settle(6);
      reg_rd(FLAGS_ADDR, 1'b0, d0, d1);
      check(d0, exp);
    end
    reg_wr(WIPE_ADDR, 8'h5a);
    settle(4);
    reg_rd(FLAGS_ADDR, 1'b0, d0, d1);
    check(d0, 8'h00);
  endtask : t_flags
  // status follows the pins; a sequential read steps to the next register
  task automatic t_status();
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] pat [2] = '{8'ha5, 8'h5a};
    foreach (pat[j]) begin
      sa <= pat[j];
      sb <= ~pat[j];
      settle(10);
      reg_rd(STATE_A_ADDR, 1'b1, d0, d1);
      check(d0, pat[j]);
      check(d1, ~pat[j]);
    end
  endtask : t_status
  // read-only and reserved places disturb nothing; reading the wipe place clears
  task automatic t_guard();
    logic [7:0] d0;
    logic k0;
    logic k1;
    logic kx;
    logic [7:0] d1;
    ev <= 8'h02;
    sa <= 8'h3c;
    settle(6);
    ev <= 8'h00;
    settle(6);
    reg_wr(STATE_A_ADDR, 8'hc3);
    reg_wr(FLAGS_ADDR, 8'h00);
    reg_rd(8'h10, 1'b0, d0, d1);
    check(d0, 8'h00);
    reg_rd(STATE_A_ADDR, 1'b0, d0, d1);
    check(d0, 8'h3c);
    reg_rd(FLAGS_ADDR, 1'b0, d0, d1);
    check(d0, 8'h02);
    reg_rd(WIPE_ADDR, 1'b0, d0, d1);
    check(d0, 8'h00);
    settle(4);
    reg_rd(FLAGS_ADDR, 1'b0, d0, d1);
    check(d0, 8'h00);
    // a second data byte lands one address on, here on the wipe place
    ev <= 8'h81;
    settle(6);
    ev <= 8'h00;
    settle(6);
    reg_rd(FLAGS_ADDR, 1'b0, d0, d1);
    check(d0, 8'h81);
    point(WIPE_ADDR - 8'h01, k0);
    i2c_ctrl_model_i.byte_xfer(8'h00, 1'b1, d1, k1);
    i2c_ctrl_model_i.byte_xfer(8'h00, 1'b1, d1, kx);
    i2c_ctrl_model_i.stop();
    check({7'h00, k0 | k1 | kx}, 8'h00);
    settle(4);
    reg_rd(FLAGS_ADDR, 1'b0, d0, d1);
    check(d0, 8'h00);
  endtask : t_guard
  // a busy device or another address gets no acknowledge
  task automatic t_refuse();
    logic [7:0] r;
    logic k;
    busy <= 1'b1;
    i2c_ctrl_model_i.start();
    i2c_ctrl_model_i.byte_xfer({DEV, 1'b0}, 1'b1, r, k);
    i2c_ctrl_model_i.stop();
    check({7'h00, k}, 8'h01);
    busy <= 1'b0;
    i2c_ctrl_model_i.start();
    i2c_ctrl_model_i.byte_xfer({DEV ^ 7'h01, 1'b0}, 1'b1, r, k);
    i2c_ctrl_model_i.stop();
    check({7'h00, k}, 8'h01);
    reg_wr(WIPE_ADDR, 8'h00);
  endtask : t_refuse
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // clock, hang limit and main sequence
  initial begin
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (100000) @(posedge mclk);
    num_errors++;
    complete_run();
  end
  initial begin
    t_reset();
    t_flags();
    t_status();
    t_guard();
    t_refuse();
    complete_run();
  end
endmodule : tb
`default_nettype wire
